// ### rtl/caddlc_pkg.sv
// Behaviour
// - Register-form add-if-nonzero writes first source plus second source when the condition is nonzero, else the first source.
// - Immediate-form add-if-nonzero adds the sign-extended nine-bit immediate when the condition is nonzero, else passes the first source.
// - Short add-if-nonzero tests the implicit condition register and adds the second source or four-bit immediate into the first operand only when it is nonzero.
// - Add-if-zero writes the sum with the second source or nine-bit immediate only when the condition is zero, else the first source.
// - Short add-if-zero tests the implicit condition register and adds into the first operand only when it is zero.
// - Address add-if-nonzero adds the second address or nine-bit immediate to the first address when the tested data is nonzero, else copies it.
// - Address add-if-zero adds the second address or nine-bit immediate when the tested data is zero, else passes the first address.
// - Word leading-ones count counts ones from bit 31 downward.
// - Packed leading-ones count works per byte or halfword lane, result in the matching lane.
// - Word leading-signs count counts bits from bit 30 down that equal bit 31.
// - Packed leading-signs count gives each lane its redundant sign bit count.
// - Word leading-zeroes count counts zeroes from bit 31 downward.
// - Packed leading-zeroes count works per byte or halfword lane, result in the matching lane.
package caddlc_pkg;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [7:0]  OFS_SRC_A  = 8'h00;
	localparam logic [7:0]  OFS_SRC_B  = 8'h04;
	localparam logic [7:0]  OFS_COND   = 8'h08;
	localparam logic [7:0]  OFS_IMPL   = 8'h0c;
	localparam logic [7:0]  OFS_IMM    = 8'h10;
	localparam logic [7:0]  OFS_CMD    = 8'h14;
	localparam logic [7:0]  OFS_RESULT = 8'h18;
	localparam logic [7:0]  OFS_FLAGS  = 8'h1c;
	localparam logic [7:0]  OFS_STATUS = 8'h20;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;

	// ********************************************************
	// Field layouts
	// ********************************************************
	localparam int IMM9_W   = 9;
	localparam int IMM4_W   = 4;
	localparam int LANE_B   = 8;
	localparam int LANE_H   = 16;
	localparam int LANE_W   = 32;
	localparam int CMD_W    = 6;
	localparam int FLAGS_W  = 4;
	localparam int STAT_TAKEN_BIT = 8;

	typedef enum logic [3:0] {
		OP_ADD_NZ  = 4'h0,
		OP_ADD_Z   = 4'h1,
		OP_AADD_NZ = 4'h2,
		OP_AADD_Z  = 4'h3,
		OP_ONES_W  = 4'h4,
		OP_ONES_B  = 4'h5,
		OP_ONES_H  = 4'h6,
		OP_SIGNS_W = 4'h7,
		OP_SIGNS_B = 4'h8,
		OP_SIGNS_H = 4'h9,
		OP_ZEROS_W = 4'ha,
		OP_ZEROS_B = 4'hb,
		OP_ZEROS_H = 4'hc
	} caddlc_op_t;

	typedef struct packed {
		logic       short_form;
		logic       use_imm;
		caddlc_op_t op;
	} caddlc_cmd_t;

	typedef struct packed {
		logic sticky_advance_overflow_flag;
		logic advance_overflow_flag;
		logic sticky_overflow_flag;
		logic overflow_flag;
	} caddlc_flags_t;

	localparam caddlc_cmd_t   CMD_RST   = '{short_form: 1'b0, use_imm: 1'b0, op: OP_ADD_NZ};
	localparam caddlc_flags_t FLAGS_RST = '{default: 1'b0};

endpackage : caddlc_pkg

// ### rtl/caddlc_top.sv
`timescale 1ns/100ps

module caddlc_top
	import caddlc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp
);

	// ********************************************************
	// Bus slave
	// ********************************************************
	logic          [7:0]  addr_q;
	logic                 hit_q;
	logic                 wr_q;
	logic                 rd_wait_q;
	logic                 take;
	logic                 wr_en;
	logic          [31:0] rd_mux;
	logic          [31:0] status_word;
	logic          [31:0] src_a_q;
	logic          [31:0] src_b_q;
	logic          [31:0] cond_q;
	logic          [31:0] impl_q;
	logic [IMM9_W-1:0]    imm_q;
	logic          [31:0] result_q;
	caddlc_cmd_t          last_cmd_q;
	logic                 taken_q;
	caddlc_flags_t        flags_q;

	assign take      = hsel && hready && htrans[1];
	assign wr_en     = wr_q && hit_q;
	// Only whole-word transfers are expected, so hsize is not decoded.
	assign hresp     = 1'b0;
	// Reads take one wait state so that read data always come from a flop.
	assign hreadyout = !rd_wait_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q    <= 8'h00;
			hit_q     <= 1'b0;
			wr_q      <= 1'b0;
		end else if (hready) begin
			addr_q    <= haddr[7:0];
			hit_q     <= take && (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
			wr_q      <= take && hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_wait_q <= 1'b0;
		end else if (rd_wait_q) begin
			rd_wait_q <= 1'b0;
		end else begin
			rd_wait_q <= take && !hwrite;
		end
	end

	always_comb begin
		status_word                 = RST_WORD;
		status_word[CMD_W-1:0]      = last_cmd_q;
		status_word[STAT_TAKEN_BIT] = taken_q;
	end

	always_comb begin
		case (addr_q)
			OFS_SRC_A:  rd_mux = src_a_q;
			OFS_SRC_B:  rd_mux = src_b_q;
			OFS_COND:   rd_mux = cond_q;
			OFS_IMPL:   rd_mux = impl_q;
			OFS_IMM:    rd_mux = {{(32 - IMM9_W){1'b0}}, imm_q};
			OFS_CMD:    rd_mux = {{(32 - CMD_W){1'b0}}, last_cmd_q};
			OFS_RESULT: rd_mux = result_q;
			OFS_FLAGS:  rd_mux = {{(32 - FLAGS_W){1'b0}}, flags_q};
			OFS_STATUS: rd_mux = status_word;
			default:    rd_mux = RST_WORD;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= RST_WORD;
		end else if (rd_wait_q) begin
			hrdata <= hit_q ? rd_mux : RST_WORD;
		end
	end

	// ********************************************************
	// Write strobes
	// ********************************************************
	logic wr_src_a;
	logic wr_src_b;
	logic wr_cond;
	logic wr_impl;
	logic wr_imm;
	logic wr_flags;

	// Writes land at the edge that ends the data phase, while hwdata still stands.
	assign wr_src_a = wr_en && (addr_q == OFS_SRC_A);
	assign wr_src_b = wr_en && (addr_q == OFS_SRC_B);
	assign wr_cond  = wr_en && (addr_q == OFS_COND);
	assign wr_impl  = wr_en && (addr_q == OFS_IMPL);
	assign wr_imm   = wr_en && (addr_q == OFS_IMM);
	assign wr_flags = wr_en && (addr_q == OFS_FLAGS);

	// ********************************************************
	// Operand selection
	// ********************************************************
	caddlc_cmd_t   cmd_in;
	logic          cmd_go;
	logic [31:0]   imm_ext;
	logic [31:0]   addend;
	logic [31:0]   cond_val;
	logic          cond_zero;
	logic          is_data_add;
	logic          taken;
	logic [31:0]   sum;

	assign cmd_in = caddlc_cmd_t'(hwdata[CMD_W-1:0]);
	assign cmd_go = wr_en && (addr_q == OFS_CMD);

	always_comb begin
		if (cmd_in.short_form) begin
			imm_ext = {{(32 - IMM4_W){imm_q[IMM4_W-1]}}, imm_q[IMM4_W-1:0]};
		end else begin
			imm_ext = {{(32 - IMM9_W){imm_q[IMM9_W-1]}}, imm_q};
		end
	end

	assign is_data_add = (cmd_in.op == OP_ADD_NZ) || (cmd_in.op == OP_ADD_Z);
	// The short form selects the implicit condition only for the data operations; for the address ones the bit still narrows the immediate.
	assign cond_val    = (cmd_in.short_form && is_data_add) ? impl_q : cond_q;
	assign cond_zero   = (cond_val == 32'h0000_0000);
	assign addend      = cmd_in.use_imm ? imm_ext : src_b_q;
	// One adder serves the data and the address forms; only the data forms update the flags.
	assign sum         = src_a_q + addend;

	always_comb begin
		case (cmd_in.op)
			OP_ADD_NZ:  taken = !cond_zero;
			OP_AADD_NZ: taken = !cond_zero;
			OP_ADD_Z:   taken = cond_zero;
			OP_AADD_Z:  taken = cond_zero;
			default:    taken = 1'b0;
		endcase
	end

	// ********************************************************
	// Leading counts
	// ********************************************************
	// Zero counts run the ones search on the inverted word and sign counts on a match mask
	// one bit below the top, so all nine counts share one search routine.
	function automatic logic [5:0] lead_ones(input logic [31:0] v, input int hi, input int w);
		logic       run;
		logic [5:0] n;
		run = 1'b1;
		n   = 6'h00;
		for (int i = 0; i < LANE_W; i++) begin
			if (i < w) begin
				if (run && v[hi-i]) begin
					n = n + 6'h01;
				end else begin
					run = 1'b0;
				end
			end
		end
		return n;
	endfunction : lead_ones

	logic [31:0] ones_b;
	logic [31:0] zeros_b;
	logic [31:0] signs_b;
	logic [31:0] ones_h;
	logic [31:0] zeros_h;
	logic [31:0] signs_h;
	logic [31:0] ones_w;
	logic [31:0] zeros_w;
	logic [31:0] signs_w;

	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_lane
			localparam int BH = LANE_B * k + LANE_B - 1;
			logic [31:0] same_b;
			assign same_b = ~(src_a_q ^ {32{src_a_q[BH]}});
			assign ones_b[LANE_B*k +: LANE_B]  = {2'h0, lead_ones(src_a_q, BH, LANE_B)};
			assign zeros_b[LANE_B*k +: LANE_B] = {2'h0, lead_ones(~src_a_q, BH, LANE_B)};
			// Bits below the lane top that match it are the redundant sign bits.
			assign signs_b[LANE_B*k +: LANE_B] = {2'h0, lead_ones(same_b, BH - 1, LANE_B - 1)};
			if (k < 2) begin : g_half
				localparam int HH = LANE_H * k + LANE_H - 1;
				logic [31:0] same_h;
				assign same_h = ~(src_a_q ^ {32{src_a_q[HH]}});
				assign ones_h[LANE_H*k +: LANE_H]  = {10'h000, lead_ones(src_a_q, HH, LANE_H)};
				assign zeros_h[LANE_H*k +: LANE_H] = {10'h000, lead_ones(~src_a_q, HH, LANE_H)};
				assign signs_h[LANE_H*k +: LANE_H] = {10'h000, lead_ones(same_h, HH - 1, LANE_H - 1)};
			end
		end
	endgenerate

	logic [31:0] same_w;
	assign same_w  = ~(src_a_q ^ {32{src_a_q[31]}});
	assign ones_w  = {26'h000_0000, lead_ones(src_a_q, 31, LANE_W)};
	assign zeros_w = {26'h000_0000, lead_ones(~src_a_q, 31, LANE_W)};
	assign signs_w = {26'h000_0000, lead_ones(same_w, 30, LANE_W - 1)};

	// ********************************************************
	// Result selection
	// ********************************************************
	logic [31:0] result_d;

	always_comb begin
		case (cmd_in.op)
			OP_ADD_NZ,
			OP_ADD_Z,
			OP_AADD_NZ,
			OP_AADD_Z:  result_d = taken ? sum : src_a_q;
			OP_ONES_W:  result_d = ones_w;
			OP_ONES_B:  result_d = ones_b;
			OP_ONES_H:  result_d = ones_h;
			OP_SIGNS_W: result_d = signs_w;
			OP_SIGNS_B: result_d = signs_b;
			OP_SIGNS_H: result_d = signs_h;
			OP_ZEROS_W: result_d = zeros_w;
			OP_ZEROS_B: result_d = zeros_b;
			OP_ZEROS_H: result_d = zeros_h;
			// Codes with no operation behind them return the first source and touch no flag.
			default:    result_d = src_a_q;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_q <= RST_WORD;
		end else if (cmd_go) begin
			result_q <= result_d;
		end
	end

	// The command record feeds the status word and changes only when a command runs.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_cmd_q <= CMD_RST;
			taken_q    <= 1'b0;
		end else if (cmd_go) begin
			last_cmd_q <= cmd_in;
			taken_q    <= taken;
		end
	end

	// ********************************************************
	// Operand registers
	// ********************************************************
	logic short_wb;

	// The short data forms write back into the first operand; untaken leaves it as it was.
	assign short_wb = cmd_go && cmd_in.short_form && is_data_add && taken;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_a_q <= RST_WORD;
		end else if (short_wb) begin
			src_a_q <= sum;
		end else if (wr_src_a) begin
			src_a_q <= hwdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_b_q <= RST_WORD;
		end else if (wr_src_b) begin
			src_b_q <= hwdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cond_q <= RST_WORD;
		end else if (wr_cond) begin
			cond_q <= hwdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			impl_q <= RST_WORD;
		end else if (wr_impl) begin
			impl_q <= hwdata;
		end
	end

	// The immediate keeps nine bits; the short forms read only its low four.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			imm_q <= {IMM9_W{1'b0}};
		end else if (wr_imm) begin
			imm_q <= hwdata[IMM9_W-1:0];
		end
	end

	// ********************************************************
	// Status flags
	// ********************************************************
	logic          ovf;
	logic          aovf;
	logic          flag_upd;
	caddlc_flags_t flags_clr;

	// An add that is not taken performs no addition, so it reports no overflow.
	assign ovf      = taken && (src_a_q[31] == addend[31]) && (sum[31] != src_a_q[31]);
	assign aovf     = taken && (sum[31] ^ sum[30]);
	assign flag_upd = cmd_go && is_data_add;
	assign flags_clr = wr_flags ?
		caddlc_flags_t'(hwdata[FLAGS_W-1:0]) : FLAGS_RST;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= FLAGS_RST;
		end else begin
			if (flag_upd) begin
				flags_q.overflow_flag         <= ovf;
				flags_q.advance_overflow_flag <= aovf;
			end
			// A sticky flag set in the cycle of its clear stays set.
			flags_q.sticky_overflow_flag <= (flag_upd && ovf) ||
				(flags_q.sticky_overflow_flag && !flags_clr.sticky_overflow_flag);
			flags_q.sticky_advance_overflow_flag <= (flag_upd && aovf) ||
				(flags_q.sticky_advance_overflow_flag &&
				!flags_clr.sticky_advance_overflow_flag);
		end
	end

endmodule : caddlc_top

// ### test/caddlc_assertions.sv
`timescale 1ns/100ps
module caddlc_chk
	import caddlc_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp
);
	// ****
	// Bus timing
	// ****
	wire logic rd  = hsel & hready & htrans[1] & !hwrite;
	wire logic wr  = hsel & hready & htrans[1] & hwrite;
	wire logic bad = (|haddr[31:8]) | (|haddr[1:0]) | (haddr[7:0] > OFS_STATUS);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_rd;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_rd_wait;
		rd |=> s_rd;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_fast;
		wr |=> hreadyout;
	endproperty
	a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
	property p_one_low;
		!hreadyout |=> hreadyout;
	endproperty
	a_one_low: assert property (p_one_low) else $error("wait state too long");
	property p_idle;
		!rd |=> hreadyout;
	endproperty
	a_idle: assert property (p_idle) else $error("stall without read");
	// Two quiet edges are needed since the load edge of read data is a design choice.
	property p_hold;
		!rd ##1 !rd |-> ##1 $stable(hrdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_bad;
		rd && bad |-> ##2 hrdata == 32'h0;
	endproperty
	a_bad: assert property (p_bad) else $error("unmapped read not zero");
	property p_resp;
		hresp == 1'b0;
	endproperty
	a_resp: assert property (p_resp) else $error("error response");
	property p_rst;
		disable iff (1'b0) !hresetn |-> hreadyout && hrdata == 32'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset outputs");
endmodule : caddlc_chk
bind caddlc_top caddlc_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp);

// ### test/caddlc_bus_model.sv
`timescale 1ns/100ps
module caddlc_bus_model (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	output logic             hung
);
	// ****
	// Single word transfers
	// ****
	initial begin
		{hsel, haddr, htrans, hwrite, hwdata, hung} = '0;
		hsize = 3'h2;
	end
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) hung = 1'b1;
	endtask : wait_rdy
	// Entered just after a rising edge; returns just after the edge that ends the data phase.
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
	endtask : xfer
endmodule : caddlc_bus_model

// ### test/cond_add_and_leading_count_test.sv
`timescale 1ns/100ps
module cond_add_and_leading_count_test import caddlc_pkg::*;;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b1;
	logic        hsel, hwrite, hung, hreadyout, hresp, ui, sf, tk, v;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  op, fl;
	logic [31:0] haddr, hwdata, hrdata, a, b, c, im, imp, ex, ad, sum;
	int          num_errors = 0;
	int          compares = 0;
	initial forever #2.5 hclk = ~hclk;
	caddlc_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp);
	caddlc_bus_model m (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hung);
	// ****
	// Helpers
	// ****
	task conclude;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
		if (hung === 1'b1) begin
			num_errors++;
			conclude();
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] x;
		m.xfer(1'b1, {24'h0, ad}, d, x);
	endtask : wr
	task automatic rdc(input logic [31:0] ad, exp);
		logic [31:0] x;
		m.xfer(1'b0, ad, 32'h0, x);
		chk(x, exp);
	endtask : rdc
	// Kind k: 0 ones, 1 redundant signs, 2 zeroes; lanes of w bits.
	function automatic logic [31:0] cnt(input logic [31:0] x, input int w, k);
		logic [31:0] res;
		logic        bv, go;
		int          n;
		res = 32'h0;
		for (int l = 0; l < 32; l += w) begin
			bv = (k == 1) ? x[l+w-1] : (k == 0);
			n = 0;
			go = 1'b1;
			for (int i = l + w - 1 - (k == 1); i >= l; i--) begin
				if (go && x[i] == bv) n++;
				else go = 1'b0;
			end
			res = res | (32'(n) << l);
		end
		return res;
	endfunction : cnt
	// ****
	// Sequence
	// ****
	initial begin
		// Reset starts high so that its falling edge reaches the design at time zero.
		hresetn <= 1'b0;
		void'($urandom(32'haeb4));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i <= 8; i++) rdc(32'(i * 4), 32'h0);
		wr(OFS_RESULT, 32'h5);
		rdc(OFS_RESULT, 32'h0);
		rdc(32'h24, 32'h0);
		rdc(32'h2, 32'h0);
		rdc(32'h100, 32'h0);
		fl = 4'h0;
		for (int t = 0; t < 120; t++) begin
			op = (t < 26) ? 4'(t % 13) : 4'($urandom_range(15));
			a = (t % 3 == 0) ? {{16{t[1]}}, {16{t[2]}}} ^ {t[4], 31'h0} : $urandom;
			b = $urandom;
			c = t[1] ? 32'h0 : $urandom;
			imp = t[2] ? 32'h0 : $urandom;
			im = $urandom_range(511);
			ui = 1'($urandom_range(1));
			sf = op < 2 && t[3];
			wr(OFS_SRC_A, a);
			wr(OFS_SRC_B, b);
			wr(OFS_COND, c);
			wr(OFS_IMPL, imp);
			wr(OFS_IMM, im);
			wr(OFS_CMD, {26'h0, sf, ui, op});
			ad = ui ? (sf ? {{28{im[3]}}, im[3:0]} : {{23{im[8]}}, im[8:0]}) : b;
			tk = ((sf ? imp : c) != 32'h0) ^ op[0];
			sum = a + ad;
			v = (a[31] == ad[31]) && (sum[31] != a[31]);
			if (op > 12) ex = a;
			else if (op > 3) ex = cnt(a, ((op - 4) % 3 == 0) ? 32 : (op - 4) % 3 * 8, (op - 4) / 3);
			else ex = tk ? sum : a;
			if (op < 2) fl = {fl[3] | (tk & (sum[31] ^ sum[30])), tk & (sum[31] ^ sum[30]),
				fl[1] | (tk & v), tk & v};
			rdc(OFS_RESULT, ex);
			rdc(OFS_FLAGS, {28'h0, fl});
			rdc(OFS_SRC_A, (sf && tk) ? sum : a);
			rdc(OFS_CMD, {26'h0, sf, ui, op});
			rdc(OFS_STATUS, {23'h0, tk & (op < 4), 2'h0, sf, ui, op});
			if (t % 5 == 0) begin
				wr(OFS_FLAGS, 32'hf);
				fl = fl & 4'h5;
				rdc(OFS_FLAGS, {28'h0, fl});
			end
		end
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i <= 8; i++) rdc(32'(i * 4), 32'h0);
		conclude();
	end
endmodule : cond_add_and_leading_count_test
